// ===== inc/bus_pkg.sv
package bus_pkg;

    // Bus timing: clk cycles per bus T-state, giving the one-third high bus clock
    localparam int unsigned TSTATE_CLKS = 3;
    localparam int unsigned PHASE_W = 4;

    // Synchronised pin inputs, bit positions
    localparam int unsigned SYNC_W = 6;
    localparam int unsigned SYN_IRQ = 0;
    localparam int unsigned SYN_NMI = 1;
    localparam int unsigned SYN_TEST_N = 2;
    localparam int unsigned SYN_RESET = 3;
    localparam int unsigned SYN_MINMAX = 4;
    localparam int unsigned SYN_HOLD = 5;
    localparam logic [SYNC_W-1:0] SYNC_INIT = 6'h14;

    // Register bus
    localparam int unsigned AXI_ADDR_W = 8;
    localparam logic [AXI_ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [AXI_ADDR_W-1:0] OFS_ADDR = 8'h04;
    localparam logic [AXI_ADDR_W-1:0] OFS_WDATA = 8'h08;
    localparam logic [AXI_ADDR_W-1:0] OFS_STATUS = 8'h0C;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Control register fields
    localparam int unsigned CTRL_GO = 0;
    localparam int unsigned CTRL_WRITE = 1;
    localparam int unsigned CTRL_IO = 2;
    localparam int unsigned CTRL_SEG_LO = 3;
    localparam int unsigned CTRL_IE = 5;
    localparam int unsigned CTRL_WAIT_TEST = 6;

    // Status register fields
    localparam int unsigned STAT_BUSY = 0;
    localparam int unsigned STAT_TEST_WAIT = 1;
    localparam int unsigned STAT_NMI_PEND = 2;
    localparam int unsigned STAT_MIN_MODE = 3;
    localparam int unsigned STAT_HOLD = 4;
    localparam int unsigned STAT_LAST_INTA = 5;
    localparam int unsigned STAT_RDATA_LO = 8;
    localparam int unsigned STAT_VECTOR_LO = 16;
    localparam int unsigned STAT_NMI_CNT_LO = 24;

    // Segment codes
    localparam logic [1:0] SEG_ALT_DATA = 2'h0;
    localparam logic [1:0] SEG_STACK = 2'h1;
    localparam logic [1:0] SEG_CODE = 2'h2;
    localparam logic [1:0] SEG_DATA = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_T1 = 3'h1,
        ST_T2 = 3'h3,
        ST_T3 = 3'h2,
        ST_TW = 3'h6,
        ST_T4 = 3'h7,
        ST_HOLD = 3'h5,
        ST_TEST = 3'h4
    } bus_state_t;

endpackage

// ===== logic/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Pins and settled levels
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] level
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic s1;
            logic s2;
            logic s3;
            logic q;
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    s1 <= INIT[i];
                    s2 <= INIT[i];
                    s3 <= INIT[i];
                    q <= INIT[i];
                end else begin
                    s1 <= pin[i];
                    s2 <= s1;
                    s3 <= s2;
                    // Change counts once second and third stage agree
                    if (s2 == s3) begin
                        q <= s3;
                    end
                end
            end
            assign level[i] = q;
        end
    endgenerate

endmodule
`default_nettype wire

// ===== logic/local_bus_unit.sv
// Added by the designer: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module local_bus_unit
    import bus_pkg::*;
#(
    parameter int unsigned T_DIV = TSTATE_CLKS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // AXI4-Lite write address
    input wire logic [bus_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [bus_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Multiplexed address/data byte
    input wire logic [7:0] mux_addr_data_lines_in,
    output logic [7:0] mux_addr_data_lines_out,
    output logic mux_addr_data_lines_oe,
    // Upper address byte
    output logic [7:0] upper_addr_byte_lines_out,
    output logic upper_addr_byte_lines_oe,
    // High address / status
    output logic [3:0] high_addr_status_lines_out,
    output logic high_addr_status_lines_oe,
    // Read strobe and space select
    output logic read_strobe_n_out,
    output logic read_strobe_n_oe,
    output logic mem_or_io_select_out,
    output logic mem_or_io_select_oe,
    // Control pins
    input wire logic ready,
    input wire logic maskable_irq_req,
    input wire logic nonmaskable_irq,
    input wire logic test_n,
    input wire logic cpu_reset,
    input wire logic min_max_select,
    input wire logic bus_hold_req
);
    import bus_pkg::*;

    typedef struct packed {
        bus_state_t state;
        logic [PHASE_W-1:0] phase;
        logic cyc_write;
        logic cyc_io;
        logic cyc_inta;
        logic [19:0] cyc_addr;
        logic [7:0] cyc_wdata;
        logic [1:0] cyc_seg;
        logic cfg_write;
        logic cfg_io;
        logic [1:0] cfg_seg;
        logic cfg_ie;
        logic [19:0] cfg_addr;
        logic [7:0] cfg_wdata;
        logic go_pend;
        logic test_req;
        logic nmi_pend;
        logic nmi_prev;
        logic [7:0] nmi_count;
        logic min_mode;
        logic last_inta;
        logic [7:0] rd_byte;
        logic [7:0] vector;
        logic [7:0] ad_out;
        logic ad_oe;
        logic [7:0] up_out;
        logic up_oe;
        logic [3:0] hi_out;
        logic hi_oe;
        logic rd_n;
        logic rd_oe;
        logic mio;
        logic mio_oe;
        logic [AXI_ADDR_W-1:0] aw_addr;
        logic aw_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic w_have;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } state_t;

    state_t s;
    state_t next_s;
    logic [SYNC_W-1:0] pins;
    logic [SYNC_W-1:0] sync;

    function automatic logic reg_mapped(input logic [AXI_ADDR_W-1:0] a);
        reg_mapped = (a == OFS_CTRL) || (a == OFS_ADDR) || (a == OFS_WDATA) ||
                     (a == OFS_STATUS);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        merge = r;
    endfunction

    // Asynchronous control pins other than ready pass the three-stage filter
    assign pins[SYN_IRQ] = maskable_irq_req;
    assign pins[SYN_NMI] = nonmaskable_irq;
    assign pins[SYN_TEST_N] = test_n;
    assign pins[SYN_RESET] = cpu_reset;
    assign pins[SYN_MINMAX] = min_max_select;
    assign pins[SYN_HOLD] = bus_hold_req;

    pin_sync #(
        .WIDTH(SYNC_W),
        .INIT(SYNC_INIT)
    ) u_sync (
        .clk(clk),
        .resetn(resetn),
        .pin(pins),
        .level(sync)
    );

    always_comb begin
        logic tick;
        logic [31:0] rd_word;
        logic [31:0] stat;
        logic [31:0] ctrl_rd;
        logic [31:0] addr_word;
        tick = 1'b0;
        rd_word = '0;
        stat = '0;
        ctrl_rd = '0;
        addr_word = '0;
        next_s = s;

        // T-state enable from the clk divider
        tick = (s.phase == PHASE_W'(T_DIV - 1));
        next_s.phase = tick ? '0 : s.phase + PHASE_W'(1);

        // Strobe falls one clk into T2, after the bus was floated at the T2 edge
        if (s.state == ST_T2 && s.phase == '0 && !s.cyc_write && !s.cyc_inta) begin
            next_s.rd_n = 1'b0;
        end

        if (tick) begin
            case (s.state)
                ST_IDLE: begin
                    next_s.min_mode = sync[SYN_MINMAX];
                    if (sync[SYN_HOLD]) begin
                        next_s.state = ST_HOLD;
                        next_s.ad_oe = 1'b0;
                        next_s.up_oe = 1'b0;
                        next_s.hi_oe = 1'b0;
                        next_s.rd_oe = 1'b0;
                        next_s.rd_n = 1'b1;
                        next_s.mio_oe = 1'b0;
                    end else if (s.nmi_pend) begin
                        next_s.nmi_pend = 1'b0;
                        next_s.nmi_count = s.nmi_count + 8'h01;
                    end else if (s.test_req) begin
                        next_s.state = ST_TEST;
                    end else if ((sync[SYN_IRQ] && s.cfg_ie) || s.go_pend) begin
                        next_s.state = ST_T1;
                        next_s.cyc_inta = sync[SYN_IRQ] && s.cfg_ie;
                        next_s.go_pend = s.go_pend && !next_s.cyc_inta ? 1'b0 : s.go_pend;
                        next_s.cyc_write = s.cfg_write && !next_s.cyc_inta;
                        next_s.cyc_io = s.cfg_io && !next_s.cyc_inta;
                        next_s.cyc_addr = s.cfg_addr;
                        next_s.cyc_wdata = s.cfg_wdata;
                        next_s.cyc_seg = s.cfg_seg;
                        next_s.last_inta = next_s.cyc_inta;
                        next_s.ad_out = s.cfg_addr[7:0];
                        next_s.ad_oe = !next_s.cyc_inta;
                        next_s.up_out = s.cfg_addr[15:8];
                        next_s.up_oe = !next_s.cyc_inta;
                        next_s.hi_out = (next_s.cyc_io || next_s.cyc_inta) ? 4'h0
                                        : s.cfg_addr[19:16];
                        next_s.hi_oe = 1'b1;
                        next_s.mio = s.min_mode ? next_s.cyc_io : !next_s.cyc_io;
                        next_s.mio_oe = 1'b1;
                        next_s.rd_n = 1'b1;
                        next_s.rd_oe = 1'b1;
                    end
                end
                ST_T1: begin
                    next_s.state = ST_T2;
                    next_s.ad_oe = s.cyc_write;
                    next_s.ad_out = s.cyc_wdata;
                end
                ST_T2: begin
                    next_s.state = ST_T3;
                end
                ST_T3, ST_TW: begin
                    if (ready) begin
                        next_s.state = ST_T4;
                        next_s.rd_n = 1'b1;
                        if (s.cyc_inta) begin
                            next_s.vector = mux_addr_data_lines_in;
                        end else if (!s.cyc_write) begin
                            next_s.rd_byte = mux_addr_data_lines_in;
                        end
                    end else begin
                        next_s.state = ST_TW;
                    end
                end
                ST_T4: begin
                    next_s.state = ST_IDLE;
                    next_s.ad_oe = 1'b0;
                    next_s.up_oe = 1'b1;
                end
                ST_HOLD: begin
                    if (!sync[SYN_HOLD]) begin
                        next_s.state = ST_IDLE;
                        next_s.up_oe = 1'b1;
                        next_s.hi_oe = 1'b1;
                        next_s.rd_oe = 1'b1;
                        next_s.mio_oe = 1'b1;
                    end
                end
                ST_TEST: begin
                    if (!sync[SYN_TEST_N]) begin
                        next_s.state = ST_IDLE;
                        next_s.test_req = 1'b0;
                    end
                end
                default: begin
                    next_s.state = ST_IDLE;
                end
            endcase
            // Status phase: low bit, enable flag, segment, refreshed each T-state
            if (next_s.state == ST_T2 || next_s.state == ST_T3 || next_s.state == ST_TW ||
                next_s.state == ST_T4) begin
                next_s.hi_out = {1'b0, s.cfg_ie, s.cyc_seg};
            end
        end

        // Edge capture; a new edge wins over the take
        next_s.nmi_prev = sync[SYN_NMI];
        if (sync[SYN_NMI] && !s.nmi_prev) begin
            next_s.nmi_pend = 1'b1;
        end

        // Register bus, write side
        if (s_axi_awvalid && s.awready) begin
            next_s.aw_have = 1'b1;
            next_s.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s.wready) begin
            next_s.w_have = 1'b1;
            next_s.w_data = s_axi_wdata;
            next_s.w_strb = s_axi_wstrb;
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end
        if (s.aw_have && s.w_have && !s.bvalid) begin
            next_s.aw_have = 1'b0;
            next_s.w_have = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = reg_mapped(s.aw_addr) ? RESP_OKAY : RESP_SLVERR;
            if (s.aw_addr == OFS_CTRL && s.w_strb[0]) begin
                next_s.cfg_write = s.w_data[CTRL_WRITE];
                next_s.cfg_io = s.w_data[CTRL_IO];
                next_s.cfg_seg = s.w_data[CTRL_SEG_LO +: 2];
                next_s.cfg_ie = s.w_data[CTRL_IE];
                if (s.w_data[CTRL_GO]) begin
                    next_s.go_pend = 1'b1;
                end
                if (s.w_data[CTRL_WAIT_TEST]) begin
                    next_s.test_req = 1'b1;
                end
            end else if (s.aw_addr == OFS_ADDR) begin
                addr_word = merge({12'h000, s.cfg_addr}, s.w_data, s.w_strb);
                next_s.cfg_addr = addr_word[19:0];
            end else if (s.aw_addr == OFS_WDATA && s.w_strb[0]) begin
                next_s.cfg_wdata = s.w_data[7:0];
            end
        end

        // Register bus, read side
        stat[STAT_BUSY] = (s.state != ST_IDLE) || s.go_pend;
        stat[STAT_TEST_WAIT] = s.test_req;
        stat[STAT_NMI_PEND] = s.nmi_pend;
        stat[STAT_MIN_MODE] = s.min_mode;
        stat[STAT_HOLD] = (s.state == ST_HOLD);
        stat[STAT_LAST_INTA] = s.last_inta;
        stat[STAT_RDATA_LO +: 8] = s.rd_byte;
        stat[STAT_VECTOR_LO +: 8] = s.vector;
        stat[STAT_NMI_CNT_LO +: 8] = s.nmi_count;
        ctrl_rd[CTRL_WRITE] = s.cfg_write;
        ctrl_rd[CTRL_IO] = s.cfg_io;
        ctrl_rd[CTRL_SEG_LO +: 2] = s.cfg_seg;
        ctrl_rd[CTRL_IE] = s.cfg_ie;
        case (s_axi_araddr)
            OFS_CTRL: rd_word = ctrl_rd;
            OFS_ADDR: rd_word = {12'h000, s.cfg_addr};
            OFS_WDATA: rd_word = {24'h00_0000, s.cfg_wdata};
            OFS_STATUS: rd_word = stat;
            default: rd_word = '0;
        endcase
        if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s.arready) begin
            next_s.rvalid = 1'b1;
            next_s.rdata = rd_word;
            next_s.rresp = reg_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end

        // Pin reset aborts any cycle at once
        if (sync[SYN_RESET]) begin
            next_s.state = ST_IDLE;
            next_s.phase = '0;
            next_s.go_pend = 1'b0;
            next_s.test_req = 1'b0;
            next_s.nmi_pend = 1'b0;
            next_s.ad_oe = 1'b0;
            next_s.up_oe = 1'b1;
            next_s.hi_oe = 1'b1;
            next_s.rd_n = 1'b1;
            next_s.rd_oe = 1'b1;
            next_s.mio_oe = 1'b1;
            next_s.min_mode = sync[SYN_MINMAX];
        end

        next_s.awready = !next_s.aw_have && !next_s.bvalid;
        next_s.wready = !next_s.w_have && !next_s.bvalid;
        next_s.arready = !next_s.rvalid;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s <= '0;
            s.state <= ST_IDLE;
            s.min_mode <= 1'b1;
            s.rd_n <= 1'b1;
            s.rd_oe <= 1'b1;
            s.up_oe <= 1'b1;
            s.hi_oe <= 1'b1;
            s.mio_oe <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bresp = s.bresp;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_arready = s.arready;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
    assign s_axi_rvalid = s.rvalid;
    assign mux_addr_data_lines_out = s.ad_out;
    assign mux_addr_data_lines_oe = s.ad_oe;
    assign upper_addr_byte_lines_out = s.up_out;
    assign upper_addr_byte_lines_oe = s.up_oe;
    assign high_addr_status_lines_out = s.hi_out;
    assign high_addr_status_lines_oe = s.hi_oe;
    assign read_strobe_n_out = s.rd_n;
    assign read_strobe_n_oe = s.rd_oe;
    assign mem_or_io_select_out = s.mio;
    assign mem_or_io_select_oe = s.mio_oe;

endmodule
`default_nettype wire

// ===== tb/local_bus_unit_props.sv
`timescale 1ns/1ps
`default_nettype none
module local_bus_unit_props (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Watched pins
    input wire logic ready,
    input wire logic min_max_select,
    input wire logic mux_addr_data_lines_oe,
    input wire logic [7:0] upper_addr_byte_lines_out,
    input wire logic upper_addr_byte_lines_oe,
    input wire logic [3:0] high_addr_status_lines_out,
    input wire logic high_addr_status_lines_oe,
    input wire logic read_strobe_n_out,
    input wire logic read_strobe_n_oe,
    input wire logic mem_or_io_select_out
);
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!resetn);

    a_read_after_float: assert property (!read_strobe_n_out |-> !mux_addr_data_lines_oe)
        else $error("read strobe low while data lines driven");
    a_strobe_min_low: assert property ($fell(read_strobe_n_out) |-> !read_strobe_n_out [*4])
        else $error("read strobe pulse too short");
    a_strobe_ends_ready: assert property ($rose(read_strobe_n_out) && read_strobe_n_oe
        |-> $past(ready))
        else $error("read strobe ended without ready");
    a_wait_holds_strobe: assert property (!read_strobe_n_out && !ready |=> !read_strobe_n_out)
        else $error("read ended while ready low");
    a_status_top_low: assert property (!read_strobe_n_out |-> high_addr_status_lines_oe
        && !high_addr_status_lines_out[3])
        else $error("top status bit not low");
    a_io_t1_low: assert property ($rose(mux_addr_data_lines_oe)
        && mem_or_io_select_out == min_max_select
        |-> high_addr_status_lines_out == 4'h0)
        else $error("high lines not low in io T1");
    a_upper_keeps: assert property (!upper_addr_byte_lines_oe ##1 !upper_addr_byte_lines_oe
        |-> $stable(upper_addr_byte_lines_out))
        else $error("floated upper byte changed");
    a_hold_strobe: assert property (!high_addr_status_lines_oe
        |-> !read_strobe_n_oe && read_strobe_n_out)
        else $error("strobe not floated high in hold");
endmodule
bind local_bus_unit local_bus_unit_props u_local_bus_unit_props (.*);
`default_nettype wire

// ===== tb/bus_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module bus_mem_model (
    // Clock
    input wire logic clk,
    // Device pins
    input wire logic rd_n,
    input wire logic ad_oe,
    input wire logic [7:0] ad,
    // Strobe-low clks per read before ready rises
    input wire logic [4:0] waits,
    // Answers
    output logic ready,
    output logic [7:0] data
);
    logic [7:0] addr = 8'h00;
    logic [4:0] cnt = 5'h00;
    initial ready = 1'h1;
    initial data = 8'h00;
    // Released lines toggle so stale data never passes
    always @(posedge clk) begin
        if (ad_oe) addr <= ad;
        cnt <= rd_n ? 5'h00 : cnt + 5'h01;
        ready <= rd_n || cnt >= waits;
        data <= rd_n ? ~data : addr ^ 8'h5A;
    end
endmodule
`default_nettype wire

// ===== tb/local_bus_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none
module local_bus_unit_tb;
    import bus_pkg::*;
    logic clk, resetn, ready, maskable_irq_req, nonmaskable_irq, test_n, cpu_reset;
    logic min_max_select, bus_hold_req, mux_addr_data_lines_oe, upper_addr_byte_lines_oe;
    logic [7:0] s_axi_awaddr, s_axi_araddr, mux_addr_data_lines_in, mux_addr_data_lines_out;
    logic [7:0] upper_addr_byte_lines_out;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
    logic [3:0] s_axi_wstrb, high_addr_status_lines_out;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, high_addr_status_lines_oe;
    logic read_strobe_n_out, read_strobe_n_oe, mem_or_io_select_out, mem_or_io_select_oe;
    logic [4:0] waits;
    int num_errors = 0;
    int checks = 0;
    wire logic [3:0] mon = {high_addr_status_lines_oe, upper_addr_byte_lines_oe, read_strobe_n_out,
        mux_addr_data_lines_oe};

    local_bus_unit u_local_bus_unit (.*);
    bus_mem_model u_bus_mem_model (.clk(clk), .rd_n(read_strobe_n_out),
        .ad_oe(mux_addr_data_lines_oe), .ad(mux_addr_data_lines_out), .waits(waits),
        .ready(ready), .data(mux_addr_data_lines_in));

    always #2.5 clk = ~clk;

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic conclude();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic limit(input int n, input int lim);
        if (n >= lim) begin
            num_errors++;
            conclude();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'h0;
        rsp = s_axi_bresp;
        limit(n, 50);
    endtask

    task automatic rd(input logic [7:0] a);
        int n;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'h0;
        rdv = s_axi_rdata;
        rsp = s_axi_rresp;
        limit(n, 50);
    endtask

    task automatic wait_for(input int b, input logic v);
        int n;
        for (n = 0; n < 300 && mon[b] !== v; n++) @(posedge clk);
        limit(n, 300);
    endtask

    task automatic idle();
        int n;
        for (n = 0; n < 60; n++) begin
            rd(OFS_STATUS);
            if (rdv[STAT_BUSY] === 1'h0) break;
        end
        limit(n, 60);
    endtask

    initial begin
        clk = 1'h0;
        resetn = 1'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, waits} = '0;
        {maskable_irq_req, nonmaskable_irq, cpu_reset, bus_hold_req} = '0;
        s_axi_wstrb = 4'hF;
        test_n = 1'h1;
        min_max_select = 1'h1;
        repeat (2) @(posedge clk);
        resetn <= 1'h1;
        rd(8'h40);
        chk("unmapped", {rdv[29:0], rsp}, {30'h0, RESP_SLVERR});
        wr(8'h40, 32'h0000_0000);
        chk("bad write", 32'(rsp), 32'(RESP_SLVERR));
        for (int s = 0; s < 4; s++) begin
            waits <= 5'(s * 3);
            wr(OFS_ADDR, 32'h000A_B3C0 | 32'(s));
            wr(OFS_CTRL, (32'(s) << CTRL_SEG_LO) | (32'(s % 2) << CTRL_IE) | 32'h0000_0001);
            wait_for(0, 1'h1);
            chk("t1 low", 32'(mux_addr_data_lines_out), 32'h0000_00C0 | 32'(s));
            chk("t1 upper", 32'(upper_addr_byte_lines_out), 32'h0000_00B3);
            chk("t1 high", 32'(high_addr_status_lines_out), 32'h0000_000A);
            wait_for(1, 1'h0);
            chk("status", 32'(high_addr_status_lines_out), 32'(s % 2 * 4 + s));
            idle();
            chk("read byte", 32'(rdv[15:8]), 32'h0000_009A ^ 32'(s));
        end
        for (int m = 0; m < 2; m++) begin
            min_max_select <= m[0];
            repeat (12) @(posedge clk);
            wr(OFS_CTRL, 32'h0000_0005);
            wait_for(0, 1'h1);
            chk("io t1 select", 32'(mem_or_io_select_out), 32'(m));
            chk("io t1 high", 32'(high_addr_status_lines_out), 32'h0000_0000);
            idle();
            chk("mode", 32'(rdv[STAT_MIN_MODE]), 32'(m));
        end
        wr(OFS_WDATA, 32'h0000_003C);
        chk("write resp", 32'(rsp), 32'(RESP_OKAY));
        wr(OFS_CTRL, 32'h0000_0003);
        wait_for(0, 1'h1);
        repeat (4) @(posedge clk);
        chk("write", 32'({mon[1:0], mux_addr_data_lines_out}), 32'h0000_033C);
        idle();
        bus_hold_req <= 1'h1;
        wait_for(3, 1'h0);
        chk("hold", 32'({mon, read_strobe_n_oe, mem_or_io_select_oe}), 32'h0000_0008);
        bus_hold_req <= 1'h0;
        wait_for(3, 1'h1);
        maskable_irq_req <= 1'h1;
        repeat (40) @(posedge clk);
        chk("masked", 32'(upper_addr_byte_lines_oe), 32'h1);
        wr(OFS_CTRL, 32'h0000_0020);
        wait_for(2, 1'h0);
        chk("ack float", 32'(mux_addr_data_lines_oe), 32'h0);
        maskable_irq_req <= 1'h0;
        idle();
        chk("ack", 32'(rdv[STAT_LAST_INTA]), 32'h1);
        nonmaskable_irq <= 1'h1;
        repeat (30) @(posedge clk);
        nonmaskable_irq <= 1'h0;
        repeat (20) @(posedge clk);
        rd(OFS_STATUS);
        chk("nmi count", {rdv[31:24], 21'h0, rdv[2:0]}, 32'h0100_0000);
        wr(OFS_CTRL, 32'h0000_0040);
        wr(OFS_CTRL, 32'h0000_0001);
        repeat (30) @(posedge clk);
        rd(OFS_STATUS);
        chk("test wait", 32'({mon[0], rdv[2:0]}), 32'h3);
        cpu_reset <= 1'h1;
        repeat (5) @(posedge clk);
        cpu_reset <= 1'h0;
        repeat (12) @(posedge clk);
        rd(OFS_STATUS);
        chk("pin reset", 32'(rdv[2:0]), 32'h0);
        wr(OFS_CTRL, 32'h0000_0040);
        repeat (20) @(posedge clk);
        test_n <= 1'h0;
        repeat (20) @(posedge clk);
        rd(OFS_STATUS);
        chk("test release", 32'(rdv[1]), 32'h0);
        conclude();
    end
endmodule
`default_nettype wire
